// *** pkg/rrr_pkg.sv ***
// Purpose: Shared constants for the regulator and signal-strength readout block
// Assumes: 8-bit register port, 125 MHz system clock
// Notes: Threshold table gives the receive level above which each code applies
package rrr_pkg;
    localparam int RRR_AW = 8;
    localparam int RRR_DW = 8;
    localparam int RRR_CW = 4;
    localparam int RRR_MVW = 11;
    localparam int RRR_VW = 6;
    localparam int RRR_NTHR = 14;
    localparam int RRR_NEV = 4;

    // Register offsets
    localparam logic [7:0] RRR_OFS_REG_READOUT = 8'h2C;
    localparam logic [7:0] RRR_OFS_PEAK_READOUT = 8'h2D;
    localparam logic [7:0] RRR_OFS_REG_CTRL = 8'h40;
    localparam logic [7:0] RRR_OFS_IRQ_STATUS = 8'h41;
    localparam logic [7:0] RRR_OFS_IRQ_MASK = 8'h42;

    // Field positions
    localparam int RRR_CODE_LSB = 4;
    localparam int RRR_ILIM_BIT = 0;
    localparam int RRR_AM_LSB = 4;
    localparam int RRR_PM_LSB = 0;
    localparam int RRR_MODE_BIT = 7;
    localparam int RRR_EXT_LSB = 3;

    // Event bits in status and mask
    localparam int RRR_EV_ADJ = 0;
    localparam int RRR_EV_ILIM = 1;
    localparam int RRR_EV_AM = 2;
    localparam int RRR_EV_PM = 3;

    // Reset values
    localparam logic [3:0] RRR_CODE_RST = 4'h0;
    localparam logic [7:0] RRR_CTRL_RST = 8'h00;
    localparam logic [3:0] RRR_MASK_RST = 4'h0;

    // Typical regulated voltage in 0.1 V units
    localparam logic [5:0] RRR_V5_BASE_DV = 6'h24;
    localparam logic [5:0] RRR_V33_BASE_DV = 6'h18;
    localparam logic [3:0] RRR_V33_MIN_CODE = 4'h5;

    // Receive level thresholds in mVrms, code n means above entry n-1
    localparam logic [10:0] RRR_THR_MV [RRR_NTHR] = '{
        11'h014, 11'h01B, 11'h025, 11'h034, 11'h048, 11'h063, 11'h088,
        11'h0BE, 11'h106, 11'h165, 11'h1F4, 11'h2AE, 11'h3B6, 11'h47E
    };
endpackage

// *** logic/rrr_peak_hold.sv ***
// Purpose: Converts one receive channel level to a code and holds its peak
// Assumes: Level input is synchronous and given in mVrms
// Notes: Peak only rises during a reception; clear returns it to zero
`timescale 1ns/1ps
module rrr_peak_hold (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Channel
    input wire logic [10:0] level_mv,
    input wire logic rx_active,
    input wire logic clear,
    output logic [3:0] peak_ff,
    output logic raised_ff
);
    logic [rrr_pkg::RRR_NTHR-1:0] above;
    logic [3:0] level_code;

    // One comparator per threshold
    genvar gi;
    generate
        for (gi = 0; gi < rrr_pkg::RRR_NTHR; gi++) begin : g_thr
            assign above[gi] = level_mv > rrr_pkg::RRR_THR_MV[gi];
        end
    endgenerate

    // Thresholds rise, so the code is the number exceeded
    always_comb begin
        level_code = 4'h0;
        for (int i = 0; i < rrr_pkg::RRR_NTHR; i++) begin
            level_code = level_code + {3'h0, above[i]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            peak_ff <= rrr_pkg::RRR_CODE_RST;
            raised_ff <= 1'b0;
        end else if (clear) begin
            peak_ff <= rrr_pkg::RRR_CODE_RST;
            raised_ff <= 1'b0;
        end else if (rx_active && level_code > peak_ff) begin
            peak_ff <= level_code;
            raised_ff <= 1'b1;
        end else begin
            raised_ff <= 1'b0;
        end
    end

    AST_PEAK_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clear |=> peak_ff == 4'h0)
        else $error("peak not cleared");
    AST_PEAK_MONO: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !clear && !rx_active |=> $stable(peak_ff))
        else $error("peak changed outside reception");
    AST_PEAK_TOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rx_active && !clear && level_mv > rrr_pkg::RRR_THR_MV[rrr_pkg::RRR_NTHR-1]
        |=> peak_ff == 4'hE)
        else $error("top code not reached");
endmodule // rrr_peak_hold

// *** logic/rrr_readout.sv ***
// Purpose: Read-only regulator and peak signal-strength readout, writable regulator code override, and interrupts
// Assumes: Inputs synchronous to sys_clk; one-cycle read and write strobes
// Notes: Read data stand one cycle after the read strobe, zero elsewhere
`timescale 1ns/1ps
module rrr_readout (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_ff,
    // Regulator side
    input wire logic adjust_done,
    input wire logic [3:0] adjust_code,
    input wire logic supply_5v_mode,
    input wire logic rf_current_limit,
    output logic [3:0] reg_code_applied_ff,
    output logic [5:0] reg_volt_dv_ff,
    output logic reg_code_undef_ff,
    // Receive side
    input wire logic rx_start,
    input wire logic rx_active,
    input wire logic peak_clear_cmd,
    input wire logic [10:0] am_level_mv,
    input wire logic [10:0] pm_level_mv,
    // Interrupt
    output logic irq_ff
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic [3:0] adj_code_ff;
    logic [7:0] ctrl_ff;
    logic ilim_ff;
    logic ilim_prev_ff;
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic [3:0] am_peak_ff;
    logic [3:0] pm_peak_ff;
    logic am_raised;
    logic pm_raised;
    logic peak_clear;
    logic mode_ext;
    logic [3:0] ext_code;
    logic [3:0] nxt_applied;
    logic [5:0] nxt_volt;
    logic nxt_undef;
    logic [3:0] events;
    logic [3:0] clr_bits;
    logic [3:0] nxt_status;
    logic [7:0] nxt_rdata;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;

    assign wr_ctrl = reg_wr && reg_addr == rrr_pkg::RRR_OFS_REG_CTRL;
    assign wr_status = reg_wr && reg_addr == rrr_pkg::RRR_OFS_IRQ_STATUS;
    assign wr_mask = reg_wr && reg_addr == rrr_pkg::RRR_OFS_IRQ_MASK;

    // Latest regulator-adjust result
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            adj_code_ff <= rrr_pkg::RRR_CODE_RST;
        end else if (adjust_done) begin
            adj_code_ff <= adjust_code;
        end
    end

    // Mode bit and externally written code
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_ff <= rrr_pkg::RRR_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= reg_wdata;
        end
    end

    assign mode_ext = ctrl_ff[rrr_pkg::RRR_MODE_BIT];
    assign ext_code = ctrl_ff[rrr_pkg::RRR_EXT_LSB +: rrr_pkg::RRR_CW];

    // Code that drives the regulators
    always_comb begin
        if (mode_ext) begin
            nxt_applied = ext_code;
        end else begin
            nxt_applied = adj_code_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_code_applied_ff <= rrr_pkg::RRR_CODE_RST;
        end else begin
            reg_code_applied_ff <= nxt_applied;
        end
    end

    // Typical voltage of the applied code, 0.1 V per step
    always_comb begin
        nxt_undef = 1'b0;
        if (supply_5v_mode) begin
            nxt_volt = rrr_pkg::RRR_V5_BASE_DV + {2'h0, reg_code_applied_ff};
        end else if (reg_code_applied_ff >= rrr_pkg::RRR_V33_MIN_CODE) begin
            nxt_volt = rrr_pkg::RRR_V33_BASE_DV
                + {2'h0, reg_code_applied_ff - rrr_pkg::RRR_V33_MIN_CODE};
        end else begin
            nxt_volt = 6'h00;
            nxt_undef = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_volt_dv_ff <= 6'h00;
            reg_code_undef_ff <= 1'b0;
        end else begin
            reg_volt_dv_ff <= nxt_volt;
            reg_code_undef_ff <= nxt_undef;
        end
    end

    // Current-limit flag
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ilim_ff <= 1'b0;
            ilim_prev_ff <= 1'b0;
        end else begin
            ilim_ff <= rf_current_limit;
            ilim_prev_ff <= ilim_ff;
        end
    end

    // A new reception or the clear command empties both peaks
    assign peak_clear = rx_start || peak_clear_cmd;

    rrr_peak_hold u_am_peak (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .level_mv(am_level_mv),
        .rx_active(rx_active),
        .clear(peak_clear),
        .peak_ff(am_peak_ff),
        .raised_ff(am_raised)
    );

    rrr_peak_hold u_pm_peak (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .level_mv(pm_level_mv),
        .rx_active(rx_active),
        .clear(peak_clear),
        .peak_ff(pm_peak_ff),
        .raised_ff(pm_raised)
    );

    // Sticky events; a new event wins over a clear in the same cycle
    always_comb begin
        events = 4'h0;
        events[rrr_pkg::RRR_EV_ADJ] = adjust_done;
        events[rrr_pkg::RRR_EV_ILIM] = ilim_ff && !ilim_prev_ff;
        events[rrr_pkg::RRR_EV_AM] = am_raised;
        events[rrr_pkg::RRR_EV_PM] = pm_raised;
        clr_bits = wr_status ? reg_wdata[rrr_pkg::RRR_NEV-1:0] : 4'h0;
        nxt_status = (status_ff & ~clr_bits) | events;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_ff <= 4'h0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mask_ff <= rrr_pkg::RRR_MASK_RST;
        end else if (wr_mask) begin
            mask_ff <= reg_wdata[rrr_pkg::RRR_NEV-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_status & mask_ff);
        end
    end

    // Read mux; unmapped addresses and idle cycles give zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                rrr_pkg::RRR_OFS_REG_READOUT: begin
                    nxt_rdata[rrr_pkg::RRR_CODE_LSB +: rrr_pkg::RRR_CW] = adj_code_ff;
                    nxt_rdata[rrr_pkg::RRR_ILIM_BIT] = ilim_ff;
                end
                rrr_pkg::RRR_OFS_PEAK_READOUT: begin
                    nxt_rdata[rrr_pkg::RRR_AM_LSB +: rrr_pkg::RRR_CW] = am_peak_ff;
                    nxt_rdata[rrr_pkg::RRR_PM_LSB +: rrr_pkg::RRR_CW] = pm_peak_ff;
                end
                rrr_pkg::RRR_OFS_REG_CTRL: begin
                    nxt_rdata = ctrl_ff;
                end
                rrr_pkg::RRR_OFS_IRQ_STATUS: begin
                    nxt_rdata[rrr_pkg::RRR_NEV-1:0] = status_ff;
                end
                rrr_pkg::RRR_OFS_IRQ_MASK: begin
                    nxt_rdata[rrr_pkg::RRR_NEV-1:0] = mask_ff;
                end
                default: begin
                    nxt_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata_ff <= 8'h00;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // Regulator side checks
    AST_ADJ_CAPTURE: assert property (
        adjust_done |=> adj_code_ff == $past(adjust_code))
        else $error("adjust result not captured");

    AST_REG_READ_CODE: assert property (
        reg_rd && reg_addr == rrr_pkg::RRR_OFS_REG_READOUT
        |=> reg_rdata_ff[7:4] == $past(adj_code_ff) && reg_rdata_ff[3:1] == 3'h0)
        else $error("regulator code readout wrong");

    AST_VOLT_5V: assert property (
        $past(rst_n) && $past(supply_5v_mode)
        |-> reg_volt_dv_ff == rrr_pkg::RRR_V5_BASE_DV + {2'h0, $past(reg_code_applied_ff)})
        else $error("5 V mode voltage wrong");

    AST_VOLT_5V_DEF: assert property (
        supply_5v_mode |=> !reg_code_undef_ff)
        else $error("5 V mode code flagged undefined");

    AST_VOLT_LOW_UNDEF: assert property (
        !supply_5v_mode && reg_code_applied_ff < rrr_pkg::RRR_V33_MIN_CODE
        |=> reg_code_undef_ff && reg_volt_dv_ff == 6'h00)
        else $error("undefined 3.3 V code not flagged");

    AST_VOLT_LOW_RANGE: assert property (
        !supply_5v_mode && reg_code_applied_ff >= rrr_pkg::RRR_V33_MIN_CODE
        |=> !reg_code_undef_ff
        && reg_volt_dv_ff == rrr_pkg::RRR_V33_BASE_DV
        + {2'h0, $past(reg_code_applied_ff) - rrr_pkg::RRR_V33_MIN_CODE})
        else $error("3.3 V mode voltage wrong");

    AST_ILIM_FLAG: assert property (
        $past(rst_n) |-> ilim_ff == $past(rf_current_limit))
        else $error("current limit flag not tracking");

    AST_ILIM_READ: assert property (
        rf_current_limit ##1 reg_rd && reg_addr == rrr_pkg::RRR_OFS_REG_READOUT
        |=> reg_rdata_ff[0])
        else $error("current limit flag not shown");

    AST_CTRL_WRITE: assert property (
        wr_ctrl |=> ctrl_ff == $past(reg_wdata))
        else $error("control write lost");

    AST_MODE_EXT: assert property (
        mode_ext && !wr_ctrl |=> reg_code_applied_ff == $past(ext_code))
        else $error("external code not applied");

    AST_MODE_ADJ: assert property (
        !mode_ext && !adjust_done |=> reg_code_applied_ff == $past(adj_code_ff))
        else $error("adjust result not applied");

    // Receive side checks
    AST_PEAK_READ: assert property (
        rx_start ##1 reg_rd && reg_addr == rrr_pkg::RRR_OFS_PEAK_READOUT
        |=> reg_rdata_ff == 8'h00)
        else $error("peaks not cleared at reception start");

    AST_PEAK_READ_DATA: assert property (
        reg_rd && reg_addr == rrr_pkg::RRR_OFS_PEAK_READOUT
        |=> reg_rdata_ff == {$past(am_peak_ff), $past(pm_peak_ff)})
        else $error("peak readout wrong");

    AST_PEAK_HOLD: assert property (
        !peak_clear && !rx_active |=> am_peak_ff == $past(am_peak_ff)
        && pm_peak_ff == $past(pm_peak_ff))
        else $error("peak changed while held");

    // Status and interrupt checks
    AST_ADJ_EVENT: assert property (
        adjust_done |=> status_ff[rrr_pkg::RRR_EV_ADJ])
        else $error("adjust event not recorded");

    AST_ILIM_EVENT: assert property (
        ilim_ff && !ilim_prev_ff |=> status_ff[rrr_pkg::RRR_EV_ILIM])
        else $error("current limit event not recorded");

    AST_AM_EVENT: assert property (
        am_raised |=> status_ff[rrr_pkg::RRR_EV_AM])
        else $error("AM peak event not recorded");

    AST_PM_EVENT: assert property (
        pm_raised |=> status_ff[rrr_pkg::RRR_EV_PM])
        else $error("PM peak event not recorded");

    AST_STATUS_CLEAR: assert property (
        wr_status && events == 4'h0
        |=> status_ff == ($past(status_ff) & ~$past(clr_bits)))
        else $error("status write one clear wrong");

    AST_STATUS_STICKY: assert property (
        !wr_status |=> (status_ff & $past(status_ff)) == $past(status_ff))
        else $error("status bit lost without clear");

    AST_SET_WINS: assert property (
        |events |=> (status_ff & $past(events)) == $past(events))
        else $error("event lost to same cycle clear");

    AST_STATUS_READ: assert property (
        reg_rd && reg_addr == rrr_pkg::RRR_OFS_IRQ_STATUS
        |=> reg_rdata_ff == {4'h0, $past(status_ff)})
        else $error("status readout wrong");

    AST_IRQ_LEVEL: assert property (
        $past(rst_n) |-> irq_ff == (|(status_ff & $past(mask_ff))))
        else $error("interrupt line wrong");

    AST_RDATA_IDLE: assert property (
        !reg_rd |=> reg_rdata_ff == 8'h00)
        else $error("read data not zero when idle");
endmodule // rrr_readout

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the regulator and peak signal-strength readout
// Assumes: Register port with one-cycle strobes and read data one cycle after the read strobe
// Notes: All stimulus changes by non-blocking assignment right after a rising edge
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] t=%0t mismatch got %0h exp %0h", $time, got, exp); end end
module testbench;
    logic sys_clk, rst_n, reg_wr, reg_rd, adjust_done, supply_5v_mode, rf_current_limit;
    logic rx_start, rx_active, peak_clear_cmd, reg_code_undef_ff, irq_ff;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
    logic [3:0] adjust_code, reg_code_applied_ff;
    logic [5:0] reg_volt_dv_ff;
    logic [10:0] am_level_mv, pm_level_mv;
    int errors, samples_checked;
    int thr[14] = '{20, 27, 37, 52, 72, 99, 136, 190, 262, 357, 500, 686, 950, 1150};

    rrr_readout rrr_readout_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .adjust_done(adjust_done), .adjust_code(adjust_code),
        .supply_5v_mode(supply_5v_mode), .rf_current_limit(rf_current_limit),
        .reg_code_applied_ff(reg_code_applied_ff), .reg_volt_dv_ff(reg_volt_dv_ff),
        .reg_code_undef_ff(reg_code_undef_ff), .rx_start(rx_start), .rx_active(rx_active),
        .peak_clear_cmd(peak_clear_cmd), .am_level_mv(am_level_mv),
        .pm_level_mv(pm_level_mv), .irq_ff(irq_ff)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Number of thresholds strictly exceeded
    function automatic logic [3:0] code_of(input int mv);
        int n;
        n = 0;
        foreach (thr[i]) if (mv > thr[i]) n++;
        return n[3:0];
    endfunction

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata_ff, exp)
    endtask

    task automatic adjust(input logic [3:0] c);
        @(posedge sys_clk);
        adjust_done <= 1'b1;
        adjust_code <= c;
        @(posedge sys_clk);
        adjust_done <= 1'b0;
    endtask

    task automatic pulse_clear();
        @(posedge sys_clk);
        peak_clear_cmd <= 1'b1;
        @(posedge sys_clk);
        peak_clear_cmd <= 1'b0;
    endtask

    // Optional start pulse, then three cycles of reception at the given levels
    task automatic rx(input int am, input int pm, input logic start);
        if (start) begin
            @(posedge sys_clk);
            rx_start <= 1'b1;
            @(posedge sys_clk);
            rx_start <= 1'b0;
        end
        @(posedge sys_clk);
        rx_active <= 1'b1;
        am_level_mv <= 11'(am);
        pm_level_mv <= 11'(pm);
        repeat (3) @(posedge sys_clk);
        rx_active <= 1'b0;
        idle(2);
    endtask

    task automatic test_done();
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200us;
        errors++;
        test_done();
    end

    initial begin
        logic [5:0] ev;
        rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        adjust_done = 1'b0; adjust_code = 4'h0; supply_5v_mode = 1'b1;
        rf_current_limit = 1'b0; rx_start = 1'b0; rx_active = 1'b0; peak_clear_cmd = 1'b0;
        am_level_mv = 11'h000; pm_level_mv = 11'h000;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values, read-only and unmapped places
        foreach (thr[i]) if (i < 6) rd(8'h2C + 8'(i), 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h2C, 8'hFF);
        wr(8'h2D, 8'hFF);
        rd(8'h2C, 8'h00);
        rd(8'h2D, 8'h00);
        // Adjust result drives the regulators in mode 0
        adjust(4'h9);
        idle(3);
        rd(8'h2C, 8'h90);
        `CHK(reg_code_applied_ff, 4'h9)
        `CHK(reg_volt_dv_ff, 6'h2D)
        wr(8'h40, 8'hE0);
        idle(3);
        `CHK(reg_code_applied_ff, 4'hC)
        `CHK(reg_volt_dv_ff, 6'h30)
        rd(8'h2C, 8'h90);
        // Every code in 3.3 V mode through the external code bits
        supply_5v_mode <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            wr(8'h40, {1'b1, 4'(c), 3'h0});
            idle(3);
            ev = (c >= 5) ? 6'(24 + c - 5) : 6'h00;
            `CHK(reg_volt_dv_ff, ev)
            `CHK(reg_code_undef_ff, 1'(c < 5))
        end
        wr(8'h40, 8'h00);
        supply_5v_mode <= 1'b1;
        adjust(4'hF);
        idle(3);
        `CHK(reg_volt_dv_ff, 6'h33)
        // Current-limit flag
        rf_current_limit <= 1'b1;
        idle(2);
        rd(8'h2C, 8'hF1);
        rf_current_limit <= 1'b0;
        idle(2);
        rd(8'h2C, 8'hF0);
        // Each threshold exactly and just above it
        for (int i = 0; i < 14; i++) begin
            rx(thr[i], thr[i] + 1, 1'b1);
            rd(8'h2D, {code_of(thr[i]), code_of(thr[i] + 1)});
        end
        rx(100, 100, 1'b0);
        rd(8'h2D, 8'hDE);
        rx(2000, 0, 1'b0);
        rd(8'h2D, 8'hEE);
        pulse_clear();
        idle(1);
        rd(8'h2D, 8'h00);
        @(posedge sys_clk);
        am_level_mv <= 11'h7D0;
        pm_level_mv <= 11'h7D0;
        idle(3);
        rd(8'h2D, 8'h00);
        rx(60, 30, 1'b1);
        rd(8'h2D, 8'h42);
        rx(40, 200, 1'b0);
        rd(8'h2D, 8'h48);
        // Read issued right behind a start pulse sees cleared peaks
        @(posedge sys_clk);
        rx_start <= 1'b1;
        @(posedge sys_clk);
        rx_start <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= 8'h2D;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata_ff, 8'h00)
        rx(0, 0, 1'b1);
        rd(8'h2D, 8'h00);
        // Status, mask and interrupt line
        wr(8'h41, 8'h0F);
        rd(8'h41, 8'h00);
        `CHK(irq_ff, 1'b0)
        wr(8'h42, 8'h04);
        rd(8'h42, 8'h04);
        rx(2000, 0, 1'b1);
        rd(8'h41, 8'h04);
        `CHK(irq_ff, 1'b1)
        wr(8'h42, 8'h00);
        idle(1);
        `CHK(irq_ff, 1'b0)
        wr(8'h42, 8'h04);
        wr(8'h41, 8'h04);
        idle(1);
        `CHK(irq_ff, 1'b0)
        rd(8'h41, 8'h00);
        wr(8'h42, 8'h02);
        rf_current_limit <= 1'b1;
        idle(3);
        `CHK(irq_ff, 1'b1)
        rd(8'h41, 8'h02);
        wr(8'h41, 8'h02);
        idle(2);
        `CHK(irq_ff, 1'b0)
        rf_current_limit <= 1'b0;
        adjust(4'h3);
        idle(2);
        rd(8'h41, 8'h01);
        `CHK(irq_ff, 1'b0)
        test_done();
    end
endmodule // testbench
